//--- hw/sensor_cmd_consts.svh
// Command codes, status layout, response lengths and reset values of the command block
`ifndef SENSOR_CMD_CONSTS_SVH
`define SENSOR_CMD_CONSTS_SVH

`define CMD_SEL_PRIMARY     8'hB0
`define CMD_SEL_SECONDARY   8'hB1
`define CMD_RAW_BRIDGE_INT  8'hA0
`define CMD_RAW_BRIDGE_EXT  8'hA1
`define CMD_AZ_BRIDGE_INT   8'hA2
`define CMD_AZ_BRIDGE_EXT   8'hA3
`define CMD_RAW_TEMP        8'hA4
`define CMD_AZ_TEMP         8'hA6
`define CMD_FULL_MEAS       8'hAA
`define CMD_RD_PRIMARY      8'h10
`define CMD_RD_SECONDARY    8'h11
`define CMD_WR_PRIMARY      8'h50
`define CMD_WR_SECONDARY    8'h51

`define STAT_BIT_CFG        1
`define STAT_BIT_BUSY       5

`define RX_BITS             6'd24
`define RESP_BITS           56
`define CNT_MAX             6'h3F
`define RESULT_BITS         5'd24

`define LEN_SPI_STATUS      3'h1
`define LEN_SPI_REG         3'h3
`define LEN_SPI_RAW         3'h4
`define LEN_SPI_FULL        3'h7
`define LEN_I2C_STATUS      4'h1
`define LEN_I2C_RAW         4'h4
`define LEN_I2C_REG         4'h5
`define LEN_I2C_FULL        4'h8

`define RST_CFG_PRIMARY     16'h0000
`define RST_CFG_SECONDARY   16'h0000

`endif

//--- hw/sensor_cmd_pkg.sv
// Types shared by the command block and its link front end
package sensor_cmd_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_MEAS = 2'b10
	} cmd_state_t;

	typedef struct packed {
		logic [5:0]  bit_cnt;
		logic [23:0] rx_shift;
		logic        frame_done;
	} link_state_t;

endpackage

//--- hw/link_side_if.sv
// Signals between the link-clock front end and the system-clock command core
`timescale 1ns/1ps
`default_nettype none

interface link_side_if;
	logic        frame_done;
	logic [23:0] rx_word;
	logic [55:0] resp_bits;

	modport front
	(
		output frame_done,
		output rx_word,
		input  resp_bits
	);

	modport core
	(
		input  frame_done,
		input  rx_word,
		output resp_bits
	);
endinterface

`default_nettype wire

//--- hw/serial_link_front.sv
// Serial front end on the link clock: shifts in the three-byte command, shifts out the response
`include "sensor_cmd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_link_front
	import sensor_cmd_pkg::*;
(
	// Link pins
	input  wire logic       link_clk_in,
	input  wire logic       link_sel_n_in,
	input  wire logic       link_mosi_in,
	output logic            link_miso_out,
	// Reset
	input  wire logic       rst_n_in,
	// Core side
	link_side_if.front      lnk
);
	link_state_t st_reg;
	link_state_t st_next;
	logic        frame_rst_n;

	// The link clock stops between frames, so the deselect pin ends each frame itself
	assign frame_rst_n = rst_n_in & ~link_sel_n_in;

	always_comb
	begin
		st_next = st_reg;
		if (st_reg.bit_cnt != `CNT_MAX)
			st_next.bit_cnt = st_reg.bit_cnt + 6'd1;
		if (st_reg.bit_cnt < `RX_BITS)
			st_next.rx_shift = {st_reg.rx_shift[22:0], link_mosi_in};
		st_next.frame_done = (st_reg.bit_cnt >= (`RX_BITS - 6'd1));
	end

	always_ff @(posedge link_clk_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Response bits are not synchronised: the core changes them on command decode, while select is still low, and on measurement done
	assign link_miso_out = (st_reg.bit_cnt < 6'(`RESP_BITS))
		? lnk.resp_bits[6'(`RESP_BITS - 1) - st_reg.bit_cnt] : 1'b0;
	assign lnk.frame_done = st_reg.frame_done;
	assign lnk.rx_word    = st_reg.rx_shift;

endmodule // serial_link_front

`default_nettype wire

//--- hw/sensor_config_select_and_response.sv
// Command core: configuration select, measurement requests and response framing
`include "sensor_cmd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sensor_config_select_and_response
	import sensor_cmd_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// Serial link
	input  wire logic        link_clk_in,
	input  wire logic        link_sel_n_in,
	input  wire logic        link_mosi_in,
	output logic             link_miso_out,
	// Measurement engine
	output logic             meas_start_out,
	output logic [15:0]      meas_cfg_out,
	output logic             meas_is_temp_out,
	output logic             meas_autozero_out,
	output logic             meas_full_out,
	input  wire logic        meas_done_in,
	input  wire logic [23:0] meas_bridge_in,
	input  wire logic [23:0] meas_temp_in,
	input  wire logic [4:0]  meas_res_bits_in,
	// Status
	output logic             cfg_sel_out,
	output logic             busy_out,
	output logic [2:0]       resp_len_spi_out,
	output logic [3:0]       resp_len_i2c_out
);
	typedef struct packed {
		logic [1:0]  sync_done;
		logic        prev_done;
		logic        cfg_sel;
		logic [15:0] meas_config_primary;
		logic [15:0] meas_config_secondary;
		cmd_state_t  st;
		logic [55:0] resp;
		logic [2:0]  len_spi;
		logic [3:0]  len_i2c;
		logic        meas_start;
		logic [15:0] meas_cfg;
		logic        meas_temp;
		logic        meas_az;
		logic        meas_full;
	} core_t;

	localparam core_t CORE_RST = '{
		sync_done:             2'h0,
		prev_done:             1'b0,
		cfg_sel:               1'b0,
		meas_config_primary:   `RST_CFG_PRIMARY,
		meas_config_secondary: `RST_CFG_SECONDARY,
		st:                    ST_IDLE,
		resp:                  56'h0,
		len_spi:               3'h0,
		len_i2c:               4'h0,
		meas_start:            1'b0,
		meas_cfg:              16'h0000,
		meas_temp:             1'b0,
		meas_az:               1'b0,
		meas_full:             1'b0
	};

	core_t       r_reg;
	core_t       r_next;
	logic        cmd_evt;
	logic [7:0]  op;
	logic [15:0] data;
	logic [15:0] meas_config_either;
	logic        go;
	logic [15:0] go_cfg;
	logic        go_temp;
	logic        go_az;
	logic        go_full;

	link_side_if lnk ();

	serial_link_front u_front
	(
		.link_clk_in   (link_clk_in),
		.link_sel_n_in (link_sel_n_in),
		.link_mosi_in  (link_mosi_in),
		.link_miso_out (link_miso_out),
		.rst_n_in      (rst_n_in),
		.lnk           (lnk)
	);

	function automatic logic [7:0] status_byte(input logic busy, input logic sel);
		logic [7:0] s;
		s = 8'h00;
		s[`STAT_BIT_BUSY] = busy;
		s[`STAT_BIT_CFG] = sel;
		return s;
	endfunction

	// Resolution below 24 bits is moved to the top so the sign sits in bit 23
	function automatic logic [23:0] left_align(input logic [23:0] v, input logic [4:0] res);
		logic [4:0] sh;
		sh = (res > `RESULT_BITS || res == 5'h00) ? 5'h00 : (`RESULT_BITS - res);
		return v << sh;
	endfunction

	assign cmd_evt = r_reg.sync_done[1] & ~r_reg.prev_done;
	assign op      = lnk.rx_word[23:16];
	assign data    = lnk.rx_word[15:0];
	assign meas_config_either = r_reg.cfg_sel ? r_reg.meas_config_secondary
		: r_reg.meas_config_primary;

	always_comb
	begin
		r_next            = r_reg;
		r_next.meas_start = 1'b0;
		r_next.sync_done  = {r_reg.sync_done[0], lnk.frame_done};
		r_next.prev_done  = r_reg.sync_done[1];
		go      = 1'b0;
		go_cfg  = meas_config_either;
		go_temp = 1'b0;
		go_az   = 1'b0;
		go_full = 1'b0;
		case (r_reg.st)
			ST_IDLE:
			begin
				if (cmd_evt)
				begin
					r_next.len_spi = `LEN_SPI_STATUS;
					r_next.len_i2c = `LEN_I2C_STATUS;
					case (op)
						`CMD_SEL_PRIMARY:
						begin
							r_next.cfg_sel = 1'b0;
							r_next.resp    = {status_byte(1'b0, 1'b0), 48'h0};
						end
						`CMD_SEL_SECONDARY:
						begin
							r_next.cfg_sel = 1'b1;
							r_next.resp    = {status_byte(1'b0, 1'b1), 48'h0};
						end
						`CMD_RAW_BRIDGE_INT, `CMD_AZ_BRIDGE_INT:
						begin
							go    = 1'b1;
							go_az = (op == `CMD_AZ_BRIDGE_INT);
						end
						`CMD_RAW_BRIDGE_EXT, `CMD_AZ_BRIDGE_EXT:
						begin
							go     = 1'b1;
							go_cfg = data;
							go_az  = (op == `CMD_AZ_BRIDGE_EXT);
						end
						`CMD_RAW_TEMP, `CMD_AZ_TEMP:
						begin
							go      = 1'b1;
							go_cfg  = 16'h0000;
							go_temp = 1'b1;
							go_az   = (op == `CMD_AZ_TEMP);
						end
						`CMD_FULL_MEAS:
						begin
							go      = 1'b1;
							go_full = 1'b1;
						end
						`CMD_RD_PRIMARY, `CMD_RD_SECONDARY:
						begin
							r_next.resp = {status_byte(1'b0, r_reg.cfg_sel),
								(op == `CMD_RD_PRIMARY) ? r_reg.meas_config_primary
								: r_reg.meas_config_secondary, 32'h0};
							r_next.len_spi = `LEN_SPI_REG;
							r_next.len_i2c = `LEN_I2C_REG;
						end
						`CMD_WR_PRIMARY:
						begin
							r_next.meas_config_primary = data;
							r_next.resp = {status_byte(1'b0, r_reg.cfg_sel), 48'h0};
						end
						`CMD_WR_SECONDARY:
						begin
							r_next.meas_config_secondary = data;
							r_next.resp = {status_byte(1'b0, r_reg.cfg_sel), 48'h0};
						end
						default:
						begin
							r_next.len_spi = r_reg.len_spi;
							r_next.len_i2c = r_reg.len_i2c;
						end
					endcase
				end
			end
			ST_MEAS:
			begin
				// Frames arriving mid-measurement are dropped; status shows busy
				if (meas_done_in)
				begin
					r_next.st = ST_IDLE;
					r_next.resp = {status_byte(1'b0, r_reg.cfg_sel),
						left_align(r_reg.meas_temp ? meas_temp_in : meas_bridge_in,
							meas_res_bits_in),
						r_reg.meas_full ? left_align(meas_temp_in, meas_res_bits_in)
							: 24'h0};
				end
			end
			default:
			begin
				r_next.st = ST_IDLE;
			end
		endcase
		if (go)
		begin
			r_next.st         = ST_MEAS;
			r_next.meas_start = 1'b1;
			r_next.meas_cfg   = go_cfg;
			r_next.meas_temp  = go_temp;
			r_next.meas_az    = go_az;
			r_next.meas_full  = go_full;
			r_next.resp       = {status_byte(1'b1, r_reg.cfg_sel), 48'h0};
			r_next.len_spi    = go_full ? `LEN_SPI_FULL : `LEN_SPI_RAW;
			r_next.len_i2c    = go_full ? `LEN_I2C_FULL : `LEN_I2C_RAW;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			r_reg <= CORE_RST;
		else
			r_reg <= r_next;
	end

	assign lnk.resp_bits     = r_reg.resp;
	assign meas_start_out    = r_reg.meas_start;
	assign meas_cfg_out      = r_reg.meas_cfg;
	assign meas_is_temp_out  = r_reg.meas_temp;
	assign meas_autozero_out = r_reg.meas_az;
	assign meas_full_out     = r_reg.meas_full;
	assign cfg_sel_out       = r_reg.cfg_sel;
	assign busy_out          = (r_reg.st == ST_MEAS);
	assign resp_len_spi_out  = r_reg.len_spi;
	assign resp_len_i2c_out  = r_reg.len_i2c;

endmodule // sensor_config_select_and_response

`default_nettype wire

//--- verif/sensor_config_select_and_response_checker.sv
// Port-level checks of the command core
`timescale 1ns/1ps
`default_nettype none

module sensor_config_select_and_response_checker
(
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic        meas_start_out,
	input wire logic [15:0] meas_cfg_out,
	input wire logic        meas_is_temp_out,
	input wire logic        meas_full_out,
	input wire logic        meas_done_in,
	input wire logic        cfg_sel_out,
	input wire logic        busy_out,
	input wire logic [2:0]  resp_len_spi_out,
	input wire logic [3:0]  resp_len_i2c_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_start;
		meas_start_out |=> !meas_start_out && busy_out;
	endproperty
	a_start: assert property (p_start) else $error("start not a single pulse");
	property p_start_idle;
		meas_start_out |-> !$past(busy_out);
	endproperty
	a_start_idle: assert property (p_start_idle) else $error("start while busy");
	property p_done;
		busy_out && meas_done_in |=> !busy_out;
	endproperty
	a_done: assert property (p_done) else $error("busy after done");
	property p_sel_hold;
		$changed(cfg_sel_out) |-> !$past(busy_out);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selection moved while busy");
	property p_rst_primary;
		$rose(rst_n_in) |-> !cfg_sel_out;
	endproperty
	a_rst_primary: assert property (p_rst_primary) else $error("reset left secondary");
	property p_temp_cfg;
		meas_start_out && meas_is_temp_out |-> meas_cfg_out == 16'h0000;
	endproperty
	a_temp_cfg: assert property (p_temp_cfg) else $error("temperature config not internal");
	property p_full_len;
		$fell(busy_out) && meas_full_out |-> resp_len_spi_out == 3'h7 && resp_len_i2c_out == 4'h8;
	endproperty
	a_full_len: assert property (p_full_len) else $error("full length wrong");
	property p_raw_len;
		$fell(busy_out) && !meas_full_out |-> resp_len_spi_out == 3'h4 && resp_len_i2c_out == 4'h4;
	endproperty
	a_raw_len: assert property (p_raw_len) else $error("raw length wrong");
endmodule // sensor_config_select_and_response_checker

bind sensor_config_select_and_response sensor_config_select_and_response_checker chk_i
(
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .meas_start_out(meas_start_out),
	.meas_cfg_out(meas_cfg_out), .meas_is_temp_out(meas_is_temp_out),
	.meas_full_out(meas_full_out), .meas_done_in(meas_done_in), .cfg_sel_out(cfg_sel_out),
	.busy_out(busy_out), .resp_len_spi_out(resp_len_spi_out),
	.resp_len_i2c_out(resp_len_i2c_out)
);

`default_nettype wire

//--- verif/host_link_model.sv
// Host master on the serial link: sends a command frame, collects the reply
`timescale 1ns/1ps
`default_nettype none

module host_link_model
(
	output logic      link_clk_out,
	output logic      link_sel_n_out,
	output logic      link_mosi_out,
	input  wire logic link_miso_in
);
	initial
	begin
		link_clk_out = 1'b0;
		link_sel_n_out = 1'b1;
		link_mosi_out = 1'b0;
	end

	task automatic xfer(input logic [23:0] w, input int n, output logic [55:0] r);
		r = '0;
		#1.3;
		link_sel_n_out = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			// Past the command the line is junk, so toggle it
			link_mosi_out = (i < 24) ? w[23 - i] : ~link_mosi_out;
			#6;
			r[55 - i] = link_miso_in;
			link_clk_out = 1'b1;
			#6;
			link_clk_out = 1'b0;
		end
		// Select must outlast the core's pickup of the frame
		#20;
		link_sel_n_out = 1'b1;
		link_mosi_out = ~link_mosi_out;
	endtask
endmodule // host_link_model

`default_nettype wire

//--- verif/sensor_config_select_and_response_tb.sv
// Self-checking bench for the command core
`timescale 1ns/1ps
`default_nettype none

module sensor_config_select_and_response_tb;
	logic        clk;
	logic        rst_n = 1'b0;
	logic        lclk, lsel_n, lmosi, miso;
	logic        start, temp, az, full, sel, busy;
	logic        done = 1'b0;
	logic [15:0] cfg, cap_cfg;
	logic        cap_temp, cap_az;
	logic [23:0] bridge, tmp;
	logic [4:0]  res;
	logic [2:0]  lspi;
	logic [3:0]  li2c;
	logic [55:0] r;
	int          failures, comparisons, cycles, eng;

	sensor_config_select_and_response sensor_config_select_and_response_i
	(
		.sys_clk_in(clk), .rst_n_in(rst_n), .link_clk_in(lclk), .link_sel_n_in(lsel_n),
		.link_mosi_in(lmosi), .link_miso_out(miso), .meas_start_out(start),
		.meas_cfg_out(cfg), .meas_is_temp_out(temp), .meas_autozero_out(az),
		.meas_full_out(full), .meas_done_in(done), .meas_bridge_in(bridge),
		.meas_temp_in(tmp), .meas_res_bits_in(res), .cfg_sel_out(sel), .busy_out(busy),
		.resp_len_spi_out(lspi), .resp_len_i2c_out(li2c)
	);
	host_link_model host_link_model_i
	(
		.link_clk_out(lclk), .link_sel_n_out(lsel_n), .link_mosi_out(lmosi),
		.link_miso_in(miso)
	);

	initial
	begin
		clk = 1'b0;
		bridge = 24'h0045E0;
		tmp = 24'hFFDD51;
		res = 5'h10;
	end
	always #2 clk = ~clk;

	// Engine answers five cycles after start
	always @(posedge clk)
	begin
		done <= (eng == 1);
		if (eng > 0)
			eng <= eng - 1;
		if (start)
		begin
			eng <= 5;
			cap_cfg <= cfg;
			cap_temp <= temp;
			cap_az <= az;
		end
		cycles <= cycles + 1;
	end

	task automatic close_out();
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [55:0] got, input logic [55:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic send(input logic [23:0] w, input int n);
		host_link_model_i.xfer(w, n, r);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 50 && busy !== 1'b0; i++)
			@(posedge clk);
	endtask

	// Unknown code leaves the reply in place for reading
	task automatic rd();
		send(24'hF00000, 56);
	endtask

	task automatic t_default();
		chk(56'(sel), 56'h0);
		send(24'hA6FFFF, 24);
		chk(56'({cap_temp, cap_az, cap_cfg}), 56'h30000);
		rd();
		chk({r[55:48] & 8'h22, r[47:24], 24'h0}, {8'h00, 24'hDD5100, 24'h0});
		// Host view: arithmetic shift back to 16 bits keeps the sign
		chk(56'($signed(r[47:24]) >>> 8), 56'hFFFFFFFFFFDD51);
	endtask

	task automatic t_select();
		send(24'h5000A5, 24);
		send(24'h511234, 24);
		send(24'hA20000, 24);
		chk(56'(cap_cfg), 56'h00A5);
		send(24'hB10000, 24);
		chk(56'(sel), 56'h1);
		send(24'hA20000, 24);
		chk(56'(cap_cfg), 56'h1234);
		rd();
		chk(56'(r[55:48] & 8'h22), 56'h02);
		send(24'hB00000, 24);
		send(24'hA00000, 24);
		chk(56'({sel, cap_cfg}), 56'h00A5);
	endtask

	task automatic t_raw_codes();
		logic [47:0] codes;
		codes = 48'hA0A1A2A3A4A6;
		for (int i = 0; i < 6; i++)
		begin
			send({codes[47 - 8 * i -: 8], 16'h0B26}, 24);
			chk(56'({cap_temp, cap_az}), 56'({i > 3, i == 2 || i == 3 || i == 5}));
			chk(56'(cap_cfg), (i == 1 || i == 3) ? 56'h0B26 : (i > 3) ? 56'h0 : 56'h00A5);
			chk(56'({lspi, li2c}), 56'h44);
		end
		rd();
		chk(56'(r[55:48] & 8'h22), 56'h00);
	endtask

	task automatic t_full();
		send(24'hAA0000, 24);
		chk(56'({lspi, li2c}), 56'h78);
		rd();
		chk({r[55:48] & 8'h22, r[47:0]}, {8'h00, 24'h45E000, 24'hDD5100});
	endtask

	// Stored words from the select scenario: primary 00A5, secondary 1234
	task automatic t_reg_read();
		send(24'h100000, 24);
		chk(56'(lspi), 56'h3);
		chk(56'(li2c), 56'h5);
		rd();
		chk(56'(r[55:32] & 24'h22FFFF), 56'h0000A5);
		send(24'h110000, 24);
		rd();
		chk(56'(r[55:32] & 24'h22FFFF), 56'h001234);
	endtask

	task automatic t_reset();
		send(24'hB10000, 24);
		chk(56'(sel), 56'h1);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk(56'(sel), 56'h0);
		send(24'hA00000, 24);
		chk(56'(cap_cfg), 56'h0000);
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		// A hung scenario is cut off by the cycle ceiling and counted as a mismatch
		fork
			begin
				t_default();
				t_select();
				t_raw_codes();
				t_full();
				t_reg_read();
				t_reset();
			end
			begin
				wait (cycles == 20000);
				failures++;
			end
		join_any
		close_out();
	end
endmodule // sensor_config_select_and_response_tb

`default_nettype wire
